// file: logic/pdc_pkg.sv
// ==========================================================
// Shared constants of the peripheral DMA channel
package pdc_pkg;
	// ==========================================================
	// Register offsets (byte addresses on AXI4-Lite)
	localparam logic [7:0] OFS_RD_POINTER = 8'h00;
	localparam logic [7:0] OFS_RD_LIMIT = 8'h04;
	localparam logic [7:0] OFS_RD_MOVED = 8'h08;
	localparam logic [7:0] OFS_RD_LIST = 8'h0C;
	localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
	localparam logic [7:0] OFS_TASK = 8'h20;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
	localparam logic [7:0] OFS_STATE = 8'h2C;
	// ==========================================================
	// Field positions
	localparam int TASK_START_BIT = 0;
	localparam int TASK_STOP_BIT = 1;
	localparam int EV_STOPPED = 0;
	localparam int EV_RD_ITEM = 1;
	localparam int EV_WR_ITEM = 2;
	localparam int EV_LOST = 3;
	localparam int EV_FAULT = 4;
	localparam int EV_W = 5;
	localparam int CH_RD = 0;
	localparam int CH_WR = 1;
	localparam int CH_N = 2;
	// ==========================================================
	// Values after reset
	localparam logic [31:0] POINTER_RST = 32'h0000_0000;
	localparam logic [15:0] LIMIT_RST = 16'h0000;
	localparam logic [EV_W-1:0] MASK_RST = 5'h00;
	// ==========================================================
	// Fabric map and responses
	localparam logic [31:0] RAM_BASE = 32'h2000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// List mode select values
	typedef enum logic [1:0] {PDC_LIST_OFF, PDC_LIST_LINEAR} pdc_list_t;
endpackage : pdc_pkg

// file: logic/pdc_bus_if.sv
`timescale 1ns/1ps
// ==========================================================
// Byte master link between the DMA channel and the RAM fabric
interface pdc_bus_if;
	logic req;
	logic write;
	logic [31:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic done;
	logic fault;
	// DMA side: holds req and payload until done
	modport dma (output req, write, addr, wdata, input rdata, done, fault);
	// Fabric side: arbitrates and answers with done
	modport fabric (input req, write, addr, wdata, output rdata, done, fault);
endinterface : pdc_bus_if

// file: logic/pdc_ram_fabric.sv
`timescale 1ns/1ps
// ==========================================================
// Multilayer fabric end: fixed-priority arbiter and data RAM
module pdc_ram_fabric import pdc_pkg::*; #(
	parameter int RAM_WORDS = 1024
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Processor port, highest natural priority
	input wire logic cpu_req_i,
	input wire logic cpu_write_i,
	input wire logic [31:0] cpu_addr_i,
	input wire logic [31:0] cpu_wdata_i,
	input wire logic [3:0] cpu_be_i,
	output logic [31:0] cpu_rdata_o,
	output logic cpu_done_o,
	// Fault exception towards the processor
	output logic fault_o,
	// DMA master
	pdc_bus_if.fabric bus
);
	localparam int AW = $clog2(RAM_WORDS);

	initial begin
		if (RAM_WORDS < 2 || (RAM_WORDS & (RAM_WORDS - 1)) != 0) begin
			$error("RAM_WORDS must be a power of two of at least 2");
		end
	end

	logic [31:0] mem [RAM_WORDS];
	logic own_cpu;
	logic own_dma;
	logic [31:0] acc_addr;
	logic acc_hit;
	logic [AW-1:0] acc_idx;

	// ==========================================================
	// Arbitration, granted again only after the done cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			own_cpu <= 1'b0;
			own_dma <= 1'b0;
		end else if (own_cpu || own_dma) begin
			own_cpu <= 1'b0;
			own_dma <= 1'b0;
		end else if (!cpu_done_o && !bus.done) begin
			own_cpu <= cpu_req_i;
			own_dma <= bus.req && !cpu_req_i;
		end
	end

	// Only the RAM window is mapped; flash is not reachable from here
	assign acc_addr = own_cpu ? cpu_addr_i : bus.addr;
	assign acc_hit = acc_addr >= RAM_BASE && (acc_addr - RAM_BASE) < 32'(RAM_WORDS * 4);
	assign acc_idx = acc_addr[AW+1:2];

	// ==========================================================
	// RAM access with byte lanes
	always_ff @(posedge clk_i) begin
		if (own_cpu && acc_hit && cpu_write_i) begin
			for (int b = 0; b < 4; b++) begin
				if (cpu_be_i[b]) begin
					mem[acc_idx][8*b +: 8] <= cpu_wdata_i[8*b +: 8];
				end
			end
		end else if (own_dma && acc_hit && bus.write) begin
			mem[acc_idx][8*acc_addr[1:0] +: 8] <= bus.wdata;
		end
	end

	// ==========================================================
	// Answers, one cycle after the grant
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cpu_done_o <= 1'b0;
			cpu_rdata_o <= 32'h0000_0000;
			bus.done <= 1'b0;
			bus.rdata <= 8'h00;
			bus.fault <= 1'b0;
			fault_o <= 1'b0;
		end else begin
			cpu_done_o <= own_cpu;
			bus.done <= own_dma;
			bus.fault <= own_dma && !acc_hit;
			fault_o <= (own_cpu || own_dma) && !acc_hit;
			if (own_cpu && acc_hit) begin
				cpu_rdata_o <= mem[acc_idx];
			end
			if (own_dma && acc_hit) begin
				bus.rdata <= mem[acc_idx][8*acc_addr[1:0] +: 8];
			end
		end
	end
endmodule : pdc_ram_fabric

// file: logic/pdc_dma_channel.sv
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// ==========================================================
// How it works
// - Bus master reaching data RAM only
// - Independent read and write channels
// - Read channel fetches exactly its byte limit
// - Write channel stores at most its limit
// - Any byte alignment, buffers may pack tightly
// - Software keeps write limit within buffer
// - Moved byte count readable after completion
// - Software loads a valid pointer first
// - No pointer check; fault possible
// - Congestion: stall, or drop bytes if configured
// - Linear list selected by list register
// - Items sit back to back in RAM
// - Item full after limit bytes moved
// - Fixed priority grant; channel waits
// - Completion event when the channel stops
module pdc_dma_channel import pdc_pkg::*; #(
	parameter int CNT_W = 16,
	parameter bit DROP_WHEN_BUSY = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// AXI4-Lite register slave
	input wire logic [7:0] s_awaddr_i,
	input wire logic s_awvalid_i,
	output logic s_awready_o,
	input wire logic [31:0] s_wdata_i,
	input wire logic [3:0] s_wstrb_i,
	input wire logic s_wvalid_i,
	output logic s_wready_o,
	output logic [1:0] s_bresp_o,
	output logic s_bvalid_o,
	input wire logic s_bready_i,
	input wire logic [7:0] s_araddr_i,
	input wire logic s_arvalid_i,
	output logic s_arready_o,
	output logic [31:0] s_rdata_o,
	output logic [1:0] s_rresp_o,
	output logic s_rvalid_o,
	input wire logic s_rready_i,
	// Peripheral side: bytes fetched from RAM
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	// Peripheral side: bytes to store in RAM
	input wire logic [7:0] wr_data_i,
	input wire logic wr_valid_i,
	input wire logic wr_last_i,
	output logic wr_ready_o,
	// Interrupt
	output logic irq_o,
	// Bus master towards the fabric
	pdc_bus_if.dma bus
);
	initial begin
		if (CNT_W < 1 || CNT_W > 16) begin
			$error("CNT_W must lie in 1..16");
		end
	end

	logic [31:0] pointer [CH_N];
	logic [CNT_W-1:0] limit [CH_N];
	logic [CNT_W-1:0] moved [CH_N];
	pdc_list_t list_sel [CH_N];
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_mask;
	logic [EV_W-1:0] ev;
	logic aw_have, w_have;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic reg_we;
	logic reg_re;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic run, stop_pend;
	logic start_req, stop_req;
	logic rd_fin, wr_fin;
	logic [31:0] rd_base, wr_base;
	logic [CNT_W-1:0] rd_cnt, wr_cnt;
	logic [CNT_W-1:0] next_rd_cnt, next_wr_cnt;
	logic wr_full, wr_lastq;
	logic [7:0] wr_byte;
	logic rd_go, done_rd, done_wr, rd_item_end, wr_item_end, finish;

	// ==========================================================
	// AXI4-Lite write path: address and data taken in either order
	assign s_awready_o = !aw_have && !s_bvalid_o;
	assign s_wready_o = !w_have && !s_bvalid_o;
	assign reg_we = aw_have && w_have && !s_bvalid_o;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_bvalid_o <= 1'b0;
			s_bresp_o <= RESP_OKAY;
		end else begin
			if (s_awvalid_i && s_awready_o) begin
				aw_have <= 1'b1;
				aw_addr <= s_awaddr_i;
			end
			if (s_wvalid_i && s_wready_o) begin
				w_have <= 1'b1;
				w_data <= s_wdata_i;
				w_strb <= s_wstrb_i;
			end
			if (reg_we) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_bvalid_o <= 1'b1;
				s_bresp_o <= (aw_addr[7:2] <= OFS_STATE[7:2]) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_bready_i) begin
				s_bvalid_o <= 1'b0;
			end
		end
	end

	// Byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// ==========================================================
	// Per-channel settings, one register set each
	for (genvar c = 0; c < CH_N; c++) begin : g_ch
		localparam logic [7:0] BASE = 8'(c * int'(OFS_CH_STRIDE));
		logic [31:0] lim_w;
		assign lim_w = merge(32'(limit[c]), w_data, w_strb);
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				pointer[c] <= POINTER_RST;
				limit[c] <= LIMIT_RST[CNT_W-1:0];
				list_sel[c] <= PDC_LIST_OFF;
			end else if (reg_we) begin
				if (aw_addr == BASE + OFS_RD_POINTER) begin
					pointer[c] <= merge(pointer[c], w_data, w_strb);
				end
				if (aw_addr == BASE + OFS_RD_LIMIT) begin
					limit[c] <= lim_w[CNT_W-1:0];
				end
				if (aw_addr == BASE + OFS_RD_LIST && w_strb[0]) begin
					list_sel[c] <= (w_data[1:0] == PDC_LIST_LINEAR) ? PDC_LIST_LINEAR : PDC_LIST_OFF;
				end
			end
		end
	end

	assign start_req = reg_we && aw_addr == OFS_TASK && w_strb[0] && w_data[TASK_START_BIT];
	assign stop_req = reg_we && aw_addr == OFS_TASK && w_strb[0] && w_data[TASK_STOP_BIT];

	// ==========================================================
	// AXI4-Lite read path, answer one cycle after address
	assign s_arready_o = !s_rvalid_o;
	assign reg_re = s_arvalid_i && s_arready_o;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_araddr_i)
			OFS_RD_POINTER: rd_mux = pointer[CH_RD];
			OFS_RD_LIMIT: rd_mux = 32'(limit[CH_RD]);
			OFS_RD_MOVED: rd_mux = 32'(moved[CH_RD]);
			OFS_RD_LIST: rd_mux = 32'(list_sel[CH_RD]);
			OFS_CH_STRIDE + OFS_RD_POINTER: rd_mux = pointer[CH_WR];
			OFS_CH_STRIDE + OFS_RD_LIMIT: rd_mux = 32'(limit[CH_WR]);
			OFS_CH_STRIDE + OFS_RD_MOVED: rd_mux = 32'(moved[CH_WR]);
			OFS_CH_STRIDE + OFS_RD_LIST: rd_mux = 32'(list_sel[CH_WR]);
			OFS_TASK: rd_mux = 32'h0000_0000;
			OFS_IRQ_STATUS: rd_mux = 32'(irq_status);
			OFS_IRQ_MASK: rd_mux = 32'(irq_mask);
			OFS_STATE: rd_mux = {28'h0000000, wr_fin, rd_fin, stop_pend, run};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_rvalid_o <= 1'b0;
			s_rdata_o <= 32'h0000_0000;
			s_rresp_o <= RESP_OKAY;
		end else if (reg_re) begin
			s_rvalid_o <= 1'b1;
			s_rdata_o <= rd_mux;
			s_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_rready_i) begin
			s_rvalid_o <= 1'b0;
		end
	end

	// ==========================================================
	// Run control: start, stop request and completion event
	assign finish = run && !bus.req && (stop_pend || (rd_fin && wr_fin));

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run <= 1'b0;
			stop_pend <= 1'b0;
		end else if (finish) begin
			run <= 1'b0;
			stop_pend <= 1'b0;
		end else if (start_req && !run) begin
			run <= 1'b1;
		end else if (stop_req && run) begin
			stop_pend <= 1'b1; // In-flight access is finished first
		end
	end

	// ==========================================================
	// Bus master: one byte access at a time, held until done
	assign done_rd = bus.req && bus.done && !bus.write;
	assign done_wr = bus.req && bus.done && bus.write;
	assign rd_go = run && !stop_pend && !rd_fin && !rd_valid_o;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus.req <= 1'b0;
			bus.write <= 1'b0;
			bus.addr <= 32'h0000_0000;
			bus.wdata <= 8'h00;
		end else if (bus.req) begin
			if (bus.done) begin
				bus.req <= 1'b0;
			end
		end else if (run && wr_full) begin
			bus.req <= 1'b1;
			bus.write <= 1'b1;
			bus.addr <= wr_base + 32'(wr_cnt);
			bus.wdata <= wr_byte;
		end else if (rd_go) begin
			bus.req <= 1'b1;
			bus.write <= 1'b0;
			bus.addr <= rd_base + 32'(rd_cnt);
		end
	end

	// ==========================================================
	// Read channel
	assign next_rd_cnt = rd_cnt + 1'b1;
	assign rd_item_end = done_rd && next_rd_cnt == limit[CH_RD];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_cnt <= '0;
			rd_base <= POINTER_RST;
			rd_fin <= 1'b1;
			rd_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
			moved[CH_RD] <= '0;
		end else begin
			if (rd_valid_o && rd_ready_i) begin
				rd_valid_o <= 1'b0;
			end
			if (start_req && !run) begin
				rd_cnt <= '0;
				rd_base <= pointer[CH_RD];
				rd_fin <= limit[CH_RD] == '0;
				moved[CH_RD] <= '0;
			end else if (done_rd) begin
				rd_valid_o <= 1'b1;
				rd_data_o <= bus.rdata;
				moved[CH_RD] <= next_rd_cnt;
				rd_cnt <= next_rd_cnt;
				if (rd_item_end) begin
					if (list_sel[CH_RD] == PDC_LIST_LINEAR) begin
						rd_base <= rd_base + 32'(limit[CH_RD]);
						rd_cnt <= '0;
					end else begin
						rd_fin <= 1'b1;
					end
				end
			end
		end
	end

	// ==========================================================
	// Write channel: one held byte; stalls or drops when the bus is slow
	assign next_wr_cnt = wr_cnt + 1'b1;
	assign wr_item_end = done_wr && (next_wr_cnt == limit[CH_WR] || wr_lastq);
	assign wr_ready_o = run && !stop_pend && !wr_fin && (DROP_WHEN_BUSY || !wr_full);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_cnt <= '0;
			wr_base <= POINTER_RST;
			wr_fin <= 1'b1;
			wr_full <= 1'b0;
			wr_lastq <= 1'b0;
			wr_byte <= 8'h00;
			moved[CH_WR] <= '0;
		end else begin
			if (start_req && !run) begin
				wr_cnt <= '0;
				wr_base <= pointer[CH_WR];
				wr_fin <= limit[CH_WR] == '0;
				moved[CH_WR] <= '0;
			end else if (done_wr) begin
				wr_full <= 1'b0;
				moved[CH_WR] <= next_wr_cnt;
				wr_cnt <= next_wr_cnt;
				if (wr_item_end) begin
					if (list_sel[CH_WR] == PDC_LIST_LINEAR) begin
						wr_base <= wr_base + 32'(limit[CH_WR]);
						wr_cnt <= '0;
					end else begin
						wr_fin <= 1'b1;
					end
				end
			end else if (!run) begin
				wr_full <= 1'b0; // Held flag cleared after a stop; the byte's write, launched in the finish cycle, still lands
			end
			if (wr_valid_i && wr_ready_o && !wr_full) begin
				wr_full <= 1'b1;
				wr_byte <= wr_data_i;
				wr_lastq <= wr_last_i;
			end
		end
	end

	// ==========================================================
	// Interrupts: sticky status, cleared by a read, set wins
	assign ev[EV_STOPPED] = finish;
	assign ev[EV_RD_ITEM] = rd_item_end;
	assign ev[EV_WR_ITEM] = wr_item_end;
	assign ev[EV_LOST] = wr_valid_i && wr_ready_o && wr_full;
	assign ev[EV_FAULT] = bus.req && bus.done && bus.fault;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_status <= '0;
			irq_mask <= MASK_RST;
		end else begin
			if (reg_re && s_araddr_i == OFS_IRQ_STATUS) begin
				irq_status <= ev;
			end else begin
				irq_status <= irq_status | ev;
			end
			if (reg_we && aw_addr == OFS_IRQ_MASK && w_strb[0]) begin
				irq_mask <= w_data[EV_W-1:0];
			end
		end
	end

	assign irq_o = |(irq_status & irq_mask);
endmodule : pdc_dma_channel

// file: tb/pdc_bus_sva.sv
`timescale 1ns/1ps
// ==========================================================
// Checker on the byte link between channel and fabric
module pdc_bus_sva import pdc_pkg::*; #(
	parameter int RAM_WORDS = 1024
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Link signals
	input wire logic req_i,
	input wire logic write_i,
	input wire logic [31:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_i,
	input wire logic done_i,
	input wire logic fault_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic in_ram;
	// Window test used by the fault window check
	assign in_ram = (addr_i >= RAM_BASE) && (addr_i < RAM_BASE + 32'(RAM_WORDS * 4));
	// ==========================================================
	// Request phases
	sequence s_launch;
		!req_i ##1 req_i;
	endsequence
	sequence s_pending;
		req_i && !done_i;
	endsequence
	req_hold_a: assert property (s_pending |=> req_i) else $error("link request dropped early");
	payload_hold_a: assert property (s_pending |=> $stable(addr_i) && $stable(write_i) && $stable(wdata_i))
		else $error("link payload moved while waiting");
	answer_bound_a: assert property (s_launch |-> !done_i ##[1:64] done_i) else $error("link answer late");
	done_pulse_a: assert property (done_i |=> !done_i) else $error("done longer than one cycle");
	done_owner_a: assert property (done_i |-> req_i) else $error("done without request");
	fault_pair_a: assert property (fault_i |-> done_i) else $error("fault without done");
	ram_only_a: assert property (done_i |-> fault_i == !in_ram) else $error("fault does not match window");
	fault_rdata_a: assert property (fault_i |-> $stable(rdata_i)) else $error("read data moved on fault");
	// Main traffic seen
	cover property (s_launch ##[1:64] (done_i && write_i));
endmodule : pdc_bus_sva

// file: tb/tb.sv
`timescale 1ns/1ps
// ==========================================================
// Bench: channel and fabric joined by the byte link
module tb import pdc_pkg::*;;
	localparam logic [7:0] WB = OFS_CH_STRIDE;
	logic clk_i, rst_n_i, awv, wv, bry, arv, rry, rd_rdy, wr_v, wr_l, c_req, c_wr;
	logic awr, wrd, bv, arr, rv, rd_v, wr_r, irq, c_done, cpu_flt, cflt;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] ws, be;
	logic [7:0] aw_a, ar_a, wr_d, rd_d;
	logic [31:0] w_d, rdat, c_a, c_wd, c_rd, dat, dat2;
	int failures, checks_done;
	pdc_bus_if pdc_bus_if_i();
	pdc_dma_channel pdc_dma_channel_i (.clk_i, .rst_n_i, .s_awaddr_i(aw_a), .s_awvalid_i(awv),
		.s_awready_o(awr), .s_wdata_i(w_d), .s_wstrb_i(ws), .s_wvalid_i(wv), .s_wready_o(wrd),
		.s_bresp_o(bresp), .s_bvalid_o(bv), .s_bready_i(bry), .s_araddr_i(ar_a), .s_arvalid_i(arv),
		.s_arready_o(arr), .s_rdata_o(rdat), .s_rresp_o(rresp), .s_rvalid_o(rv), .s_rready_i(rry),
		.rd_data_o(rd_d), .rd_valid_o(rd_v), .rd_ready_i(rd_rdy), .wr_data_i(wr_d), .wr_valid_i(wr_v),
		.wr_last_i(wr_l), .wr_ready_o(wr_r), .irq_o(irq), .bus(pdc_bus_if_i));
	pdc_ram_fabric #(.RAM_WORDS(1024)) pdc_ram_fabric_i (.clk_i, .rst_n_i, .cpu_req_i(c_req),
		.cpu_write_i(c_wr), .cpu_addr_i(c_a), .cpu_wdata_i(c_wd), .cpu_be_i(be), .cpu_rdata_o(c_rd),
		.cpu_done_o(c_done), .fault_o(cpu_flt), .bus(pdc_bus_if_i));
	pdc_bus_sva #(.RAM_WORDS(1024)) pdc_bus_sva_i (.clk_i, .rst_n_i, .req_i(pdc_bus_if_i.req),
		.write_i(pdc_bus_if_i.write), .addr_i(pdc_bus_if_i.addr), .wdata_i(pdc_bus_if_i.wdata),
		.rdata_i(pdc_bus_if_i.rdata), .done_i(pdc_bus_if_i.done), .fault_i(pdc_bus_if_i.fault));
	// ==========================================================
	// Shared tasks
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	// A wait that ran out ends the run at once
	task tmo;
		failures++;
		$display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
		tally_and_finish();
	endtask : tmo
	task axw(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		aw_a <= a;
		w_d <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk_i);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv) break;
		end
		if (i == 100) tmo();
		resp = bresp;
		bry <= 1'b0;
	endtask : axw
	task axr(input logic [7:0] a);
		int i;
		@(posedge clk_i);
		ar_a <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk_i);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		if (i == 100) tmo();
		dat = rdat;
		resp = rresp;
		rry <= 1'b0;
	endtask : axr
	task cpu(input logic w, input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		c_req <= 1'b1;
		c_wr <= w;
		c_a <= a;
		c_wd <= d;
		for (i = 0; i < 100; i++) begin
			@(posedge clk_i);
			if (c_done) break;
		end
		if (i == 100) tmo();
		dat2 = c_rd;
		cflt = cpu_flt;
		c_req <= 1'b0;
	endtask : cpu
	task setch(input logic [7:0] b, input logic [31:0] p, input logic [31:0] l, input logic [31:0] m);
		axw(b + OFS_RD_POINTER, p);
		axw(b + OFS_RD_LIMIT, l);
		axw(b + OFS_RD_LIST, m);
	endtask : setch
	task wirq;
		int i;
		for (i = 0; i < 400; i++) begin
			@(posedge clk_i);
			if (irq === 1'b1) break;
		end
		if (i == 400) tmo();
	endtask : wirq
	// Consume n fetched bytes, expected low byte first
	task take(input int n, input logic [63:0] e);
		int i, k;
		k = 0;
		rd_rdy <= 1'b1;
		for (i = 0; i < 400 && k < n; i++) begin
			@(posedge clk_i);
			if (rd_v === 1'b1) begin
				chk({24'h0, rd_d}, {24'h0, e[8*k+:8]});
				k++;
			end
		end
		if (k < n) tmo();
		rd_rdy <= 1'b0;
	endtask : take
	// Offer n bytes, the last one closes the item
	task give(input int n, input logic [31:0] d);
		int i, j;
		for (j = 0; j < n; j++) begin
			@(posedge clk_i);
			wr_v <= 1'b1;
			wr_d <= d[8*j+:8];
			wr_l <= (j == n - 1);
			for (i = 0; i < 100; i++) begin
				@(posedge clk_i);
				if (wr_r) break;
			end
			if (i == 100) tmo();
			wr_v <= 1'b0;
		end
	endtask : give
	// ==========================================================
	// Scenarios
	task t_regs;
		axr(WB + OFS_RD_LIMIT);
		chk(dat, {16'h0, LIMIT_RST});
		axw(8'h30, 32'h1);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		axr(8'h30);
		chk(dat, 32'h0);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		axw(OFS_RD_MOVED, 32'h7);
		axr(OFS_RD_MOVED);
		chk(dat, 32'h0);
		$display("test regs done");
	endtask : t_regs
	task t_read;
		cpu(1'b1, RAM_BASE, 32'h44332211);
		cpu(1'b1, RAM_BASE + 32'h4, 32'h88776655);
		cpu(1'b1, RAM_BASE + 32'h8, 32'hCCBBAA99);
		setch(8'h00, RAM_BASE, 32'h5, 32'h0);
		setch(WB, RAM_BASE + 32'h5, 32'h0, 32'h0);
		axw(OFS_TASK, 32'h1);
		// Processor competes for RAM while the channel fetches
		fork
			take(5, 64'h55_4433_2211);
			cpu(1'b0, RAM_BASE + 32'h8, 32'h0);
		join
		chk(dat2, 32'hCCBBAA99);
		chk({31'h0, cflt}, 32'h0);
		axw(OFS_IRQ_MASK, 32'h0);
		axr(OFS_STATE);
		chk(dat & 32'h1, 32'h0);
		chk({31'h0, irq}, 32'h0);
		chk({31'h0, rd_v}, 32'h0);
		axw(OFS_IRQ_MASK, 32'h1);
		chk({31'h0, irq}, 32'h1);
		axr(OFS_RD_MOVED);
		chk(dat, 32'h5);
		axr(OFS_IRQ_STATUS);
		chk(dat & 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h0);
		$display("test read done");
	endtask : t_read
	task t_write;
		setch(8'h00, RAM_BASE, 32'h0, 32'h0);
		setch(WB, RAM_BASE + 32'h5, 32'h6, 32'h0);
		axw(OFS_TASK, 32'h1);
		give(4, 32'hA4A3A2A1);
		wirq();
		axr(WB + OFS_RD_MOVED);
		chk(dat, 32'h4);
		cpu(1'b0, RAM_BASE + 32'h4, 32'h0);
		chk(dat2, 32'hA3A2A155);
		cpu(1'b0, RAM_BASE + 32'h8, 32'h0);
		chk(dat2, 32'hCCBBAAA4);
		axr(OFS_IRQ_STATUS);
		chk(dat & 32'h5, 32'h5);
		$display("test write done");
	endtask : t_write
	task t_list;
		setch(8'h00, RAM_BASE, 32'h4, {30'h0, PDC_LIST_LINEAR});
		setch(WB, RAM_BASE, 32'h0, 32'h0);
		axw(OFS_TASK, 32'h1);
		take(8, 64'hA3A2A155_44332211);
		axw(OFS_TASK, 32'h2);
		wirq();
		axr(OFS_IRQ_STATUS);
		chk(dat & 32'h3, 32'h3);
		// Release a byte that may still be held
		rd_rdy <= 1'b1;
		repeat (2) @(posedge clk_i);
		rd_rdy <= 1'b0;
		$display("test list done");
	endtask : t_list
	task t_fault;
		setch(8'h00, 32'h1000_0000, 32'h1, 32'h0);
		axw(OFS_IRQ_MASK, 32'h10);
		axw(OFS_TASK, 32'h1);
		wirq();
		axr(OFS_IRQ_STATUS);
		chk(dat & 32'h10, 32'h10);
		// Processor access outside the RAM window faults as well
		cpu(1'b0, 32'h1000_0000, 32'h0);
		chk({31'h0, cflt}, 32'h1);
		$display("test fault done");
	endtask : t_fault
	// ==========================================================
	// Clock and main sequence
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		{awv, wv, bry, arv, rry, rd_rdy, wr_v, wr_l, c_req, c_wr} = '0;
		{aw_a, ar_a, wr_d, w_d, c_a, c_wd} = '0;
		ws = 4'hF;
		be = 4'hF;
		failures = 0;
		checks_done = 0;
		rst_n_i = 1'b0;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_read();
		t_write();
		t_list();
		t_fault();
		tally_and_finish();
	end
endmodule : tb
